// ### verilog/bioc_cfg.svh
`ifndef BIOC_CFG_SVH
`define BIOC_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define BIOC_IDX_MODE 6'h10
`define BIOC_IDX_EQ 6'h11
`define BIOC_IDX_BAND_A 6'h12
`define BIOC_IDX_BAND_B 6'h13
`define BIOC_IDX_FMT 6'h18

// Reset values
`define BIOC_RST_MODE 8'h20
`define BIOC_RST_EQ 8'h00
`define BIOC_RST_BAND 8'h00
`define BIOC_RST_FMT 8'h70

// Writable bits; the rest read as zero
`define BIOC_MASK_MODE 8'h60
`define BIOC_MASK_EQ 8'hff
`define BIOC_MASK_BAND 8'hff
`define BIOC_MASK_FMT 8'hfe

// Field positions
`define BIOC_MODE_HI 6
`define BIOC_MODE_LO 5
`define BIOC_EQ_ADATA_HI 7
`define BIOC_EQ_ADATA_LO 6
`define BIOC_EQ_BDATA_HI 5
`define BIOC_EQ_BDATA_LO 4
`define BIOC_EQ_ACLK_HI 3
`define BIOC_EQ_ACLK_LO 2
`define BIOC_EQ_BCLK_HI 1
`define BIOC_EQ_BCLK_LO 0
`define BIOC_FMT_ACTIVE_INV 7
`define BIOC_FMT_LINE_INV 6
`define BIOC_FMT_FRAME_INV 5
`define BIOC_FMT_SINGLE_LINK 4
`define BIOC_FMT_A_WIDE 3
`define BIOC_FMT_B_WIDE 2
`define BIOC_FMT_A_LOW 1

// Equalization codes and decoded levels
`define BIOC_EQ_NONE 2'h0
`define BIOC_EQ_1DB 2'h1
`define BIOC_EQ_2DB 2'h3
`define BIOC_LVL_0DB 2'h0
`define BIOC_LVL_1DB 2'h1
`define BIOC_LVL_2DB 2'h2

// Valid input clock band codes, 5 MHz steps
`define BIOC_BAND_MIN 8'h08
`define BIOC_BAND_MAX 8'h64

// Colour bits carried by the fourth lane per colour
`define BIOC_EXTRA_BITS 2

`endif

// ### verilog/bioc_pkg.sv
package bioc_pkg;

    typedef enum logic [1:0] {
        BIOC_MODE_DUAL = 2'h0,
        BIOC_MODE_SINGLE = 2'h1,
        BIOC_MODE_TWO_SINGLE = 2'h2,
        BIOC_MODE_RSVD = 2'h3
    } bioc_chan_mode_t;

    typedef struct packed {
        logic [7:0] modeReg;
        logic [7:0] eqReg;
        logic [7:0] bandAReg;
        logic [7:0] bandBReg;
        logic [7:0] fmtReg;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic activeFlag;
        logic lineSync;
        logic frameSync;
        logic [1:0] aDataLvl;
        logic [1:0] bDataLvl;
        logic [1:0] aClkLvl;
        logic [1:0] bClkLvl;
        logic aBandOk;
        logic bBandOk;
        logic [1:0] chanMode;
        logic outAEn;
        logic outBEn;
        logic dual;
        logic twoSingle;
        logic aWide;
        logic bWide;
        logic aLow;
    } bioc_state_t;

endpackage : bioc_pkg

// ### verilog/bioc_lane_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "bioc_cfg.svh"

module bioc_lane_map #(
    parameter int COLOUR_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3*COLOUR_W-1:0] pixel,
    input wire logic laneEnable,
    input wire logic fourthEnable,
    input wire logic lowBitsOnFourth,
    output logic [3*(COLOUR_W-`BIOC_EXTRA_BITS)-1:0] mainLanes,
    output logic [3*`BIOC_EXTRA_BITS-1:0] fourthLane
);
    localparam int MAIN_W = COLOUR_W - `BIOC_EXTRA_BITS;
    localparam int EX_W = `BIOC_EXTRA_BITS;

    typedef struct packed {
        logic [3*MAIN_W-1:0] mainLanes;
        logic [3*EX_W-1:0] fourth;
    } bioc_map_state_t;

    bioc_map_state_t stateReg;
    bioc_map_state_t stateNext;
    logic [3*MAIN_W-1:0] mainSel;
    logic [3*EX_W-1:0] fourthSel;

    genvar c;
    for (c = 0; c < 3; c = c + 1) begin : g_colour
        logic [COLOUR_W-1:0] colour;
        assign colour = pixel[c*COLOUR_W +: COLOUR_W];
        // Low-bit format puts the top bits on the main lanes, so a disabled
        // fourth lane simply truncates 24 bit colour to 18 bit
        assign mainSel[c*MAIN_W +: MAIN_W] = lowBitsOnFourth ?
            colour[COLOUR_W-1 -: MAIN_W] : colour[MAIN_W-1:0];
        assign fourthSel[c*EX_W +: EX_W] = lowBitsOnFourth ?
            colour[EX_W-1:0] : colour[COLOUR_W-1 -: EX_W];
    end

    always_comb begin
        stateNext = stateReg;
        stateNext.mainLanes = laneEnable ? mainSel : '0;
        stateNext.fourth = (laneEnable && fourthEnable) ? fourthSel : '0;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign mainLanes = stateReg.mainLanes;
    assign fourthLane = stateReg.fourth;

endmodule : bioc_lane_map

`default_nettype wire

// ### verilog/bioc_regs.sv
// Overview of operation
// - Each input data-lane equalization field decodes 00 none, 01 1 dB, 11 2 dB, 10 reserved.
// - The two clock-lane equalization fields use the same encoding, none after reset.
// - Each input clock band register holds the frequency in 5 MHz steps, 08h..64h valid.
// - The active pixel flag is high during active pixels when not inverted, low when inverted.
// - Line sync is active high when its invert bit is 0 and active low when 1, the reset.
// - Frame sync is active high when its invert bit is 0 and active low when 1, the reset.
// - Link bit 0 enables both outputs, dual link for modes 00/01, two single links for 10.
// - Link bit 1, the reset, runs one single link with output A on and output B off.
// - Output A runs 18 bit with its fourth lane off at 0 and 24 bit with it on at 1.
// - Output B runs 18 bit with its fourth lane off at 0 and 24 bit with it on at 1 while link bit is 0.
// - Output A fourth lane carries the two top bits per colour at 0, the two low bits at 1.
// - Format 1 with colour depth 0 turns 24 bit input into 18 bit by dropping two low bits.
// - Channel mode codes 00 dual, 01 single (reset), 10 two single receivers, 11 reserved.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "bioc_cfg.svh"

module bioc_regs #(
    parameter int COLOUR_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic activeFlagIn,
    input wire logic lineSyncIn,
    input wire logic frameSyncIn,
    input wire logic [3*COLOUR_W-1:0] pixelAIn,
    input wire logic [3*COLOUR_W-1:0] pixelBIn,
    output logic activePixelFlag,
    output logic lineSync,
    output logic frameSync,
    output logic [1:0] inADataEqLevel,
    output logic [1:0] inBDataEqLevel,
    output logic [1:0] inAClockEqLevel,
    output logic [1:0] inBClockEqLevel,
    output logic [7:0] inAClockBand,
    output logic [7:0] inBClockBand,
    output logic inAClockBandValid,
    output logic inBClockBandValid,
    output logic [1:0] channelMode,
    output logic outAEnable,
    output logic outBEnable,
    output logic dualLink,
    output logic twoSingleLinks,
    output logic outAFourthLaneEnable,
    output logic outBFourthLaneEnable,
    output logic [3*(COLOUR_W-`BIOC_EXTRA_BITS)-1:0] outAColour18,
    output logic [3*(COLOUR_W-`BIOC_EXTRA_BITS)-1:0] outBColour18,
    output logic [3*`BIOC_EXTRA_BITS-1:0] outAFourthLane,
    output logic [3*`BIOC_EXTRA_BITS-1:0] outBFourthLane
);
    localparam int MAIN_W = 3 * (COLOUR_W - `BIOC_EXTRA_BITS);
    localparam int EX_W = 3 * `BIOC_EXTRA_BITS;

    // Sync outputs rest at their inactive level, so the inverted ones idle high
    localparam bioc_pkg::bioc_state_t STATE_RST = '{
        modeReg: `BIOC_RST_MODE,
        eqReg: `BIOC_RST_EQ,
        bandAReg: `BIOC_RST_BAND,
        bandBReg: `BIOC_RST_BAND,
        fmtReg: `BIOC_RST_FMT,
        rdata: 32'h0,
        ready: 1'h0,
        err: 1'h0,
        activeFlag: 1'h0,
        lineSync: 1'h1,
        frameSync: 1'h1,
        aDataLvl: `BIOC_LVL_0DB,
        bDataLvl: `BIOC_LVL_0DB,
        aClkLvl: `BIOC_LVL_0DB,
        bClkLvl: `BIOC_LVL_0DB,
        aBandOk: 1'h0,
        bBandOk: 1'h0,
        chanMode: bioc_pkg::BIOC_MODE_SINGLE,
        outAEn: 1'h1,
        outBEn: 1'h0,
        dual: 1'h0,
        twoSingle: 1'h0,
        aWide: 1'h0,
        bWide: 1'h0,
        aLow: 1'h0
    };

    bioc_pkg::bioc_state_t stateReg;
    bioc_pkg::bioc_state_t stateNext;

    logic setupPhase;
    logic accessDone;
    logic addrHit;
    logic [7:0] readMux;
    logic [5:0] wordIdx;
    logic writeStrobe;
    logic [1:0] modeNow;

    // Reserved code 10 is stored as written but drives no equalization
    function automatic logic [1:0] eq_level(input logic [1:0] code);
        logic [1:0] lvl;
        lvl = `BIOC_LVL_0DB;
        unique case (code)
            `BIOC_EQ_1DB: lvl = `BIOC_LVL_1DB;
            `BIOC_EQ_2DB: lvl = `BIOC_LVL_2DB;
            default: lvl = `BIOC_LVL_0DB;
        endcase
        return lvl;
    endfunction : eq_level

    function automatic logic band_ok(input logic [7:0] band);
        return (band >= `BIOC_BAND_MIN) && (band <= `BIOC_BAND_MAX);
    endfunction : band_ok

    assign wordIdx = paddr[7:2];
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && stateReg.ready;
    assign writeStrobe = accessDone && pwrite && pstrb[0] && !stateReg.err;
    assign modeNow = stateReg.modeReg[`BIOC_MODE_HI:`BIOC_MODE_LO];

    always_comb begin
        addrHit = 1'h1;
        readMux = 8'h0;
        unique case (wordIdx)
            `BIOC_IDX_MODE: readMux = stateReg.modeReg;
            `BIOC_IDX_EQ: readMux = stateReg.eqReg;
            `BIOC_IDX_BAND_A: readMux = stateReg.bandAReg;
            `BIOC_IDX_BAND_B: readMux = stateReg.bandBReg;
            `BIOC_IDX_FMT: readMux = stateReg.fmtReg;
            default: addrHit = 1'h0;
        endcase
    end

    always_comb begin
        stateNext = stateReg;
        // Bus slave: answer is prepared in the setup cycle so that pready
        // comes from a flop and the access phase never waits
        stateNext.ready = 1'h0;
        stateNext.err = 1'h0;
        if (setupPhase) begin
            stateNext.ready = 1'h1;
            stateNext.err = !addrHit;
            stateNext.rdata = {24'h0, readMux};
        end
        if (writeStrobe) begin
            unique case (wordIdx)
                `BIOC_IDX_MODE: stateNext.modeReg = pwdata[7:0] & `BIOC_MASK_MODE;
                `BIOC_IDX_EQ: stateNext.eqReg = pwdata[7:0] & `BIOC_MASK_EQ;
                `BIOC_IDX_BAND_A: stateNext.bandAReg = pwdata[7:0] & `BIOC_MASK_BAND;
                `BIOC_IDX_BAND_B: stateNext.bandBReg = pwdata[7:0] & `BIOC_MASK_BAND;
                `BIOC_IDX_FMT: stateNext.fmtReg = pwdata[7:0] & `BIOC_MASK_FMT;
                default: stateNext.fmtReg = stateReg.fmtReg;
            endcase
        end

        stateNext.aDataLvl = eq_level(stateReg.eqReg[`BIOC_EQ_ADATA_HI:`BIOC_EQ_ADATA_LO]);
        stateNext.bDataLvl = eq_level(stateReg.eqReg[`BIOC_EQ_BDATA_HI:`BIOC_EQ_BDATA_LO]);
        stateNext.aClkLvl = eq_level(stateReg.eqReg[`BIOC_EQ_ACLK_HI:`BIOC_EQ_ACLK_LO]);
        stateNext.bClkLvl = eq_level(stateReg.eqReg[`BIOC_EQ_BCLK_HI:`BIOC_EQ_BCLK_LO]);
        stateNext.aBandOk = band_ok(stateReg.bandAReg);
        stateNext.bBandOk = band_ok(stateReg.bandBReg);

        // Sync inputs arrive active high from the video path on this clock
        stateNext.activeFlag = activeFlagIn ^ stateReg.fmtReg[`BIOC_FMT_ACTIVE_INV];
        stateNext.lineSync = lineSyncIn ^ stateReg.fmtReg[`BIOC_FMT_LINE_INV];
        stateNext.frameSync = frameSyncIn ^ stateReg.fmtReg[`BIOC_FMT_FRAME_INV];

        stateNext.chanMode = modeNow;
        stateNext.outAEn = 1'h1;
        stateNext.outBEn = !stateReg.fmtReg[`BIOC_FMT_SINGLE_LINK];
        // With link bit 0, reserved mode 11 enables both outputs but claims neither pairing
        stateNext.dual = !stateReg.fmtReg[`BIOC_FMT_SINGLE_LINK]
            && ((modeNow == bioc_pkg::BIOC_MODE_DUAL)
            || (modeNow == bioc_pkg::BIOC_MODE_SINGLE));
        stateNext.twoSingle = !stateReg.fmtReg[`BIOC_FMT_SINGLE_LINK]
            && (modeNow == bioc_pkg::BIOC_MODE_TWO_SINGLE);
        stateNext.aWide = stateReg.fmtReg[`BIOC_FMT_A_WIDE];
        // Folding the link bit in here keeps the fourth-lane enable a plain flop
        stateNext.bWide = stateReg.fmtReg[`BIOC_FMT_B_WIDE]
            && !stateReg.fmtReg[`BIOC_FMT_SINGLE_LINK];
        stateNext.aLow = stateReg.fmtReg[`BIOC_FMT_A_LOW];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateReg <= STATE_RST;
        end else begin
            stateReg <= stateNext;
        end
    end

    logic [1:0][3*COLOUR_W-1:0] pixelArr;
    logic [1:0] laneEnArr;
    logic [1:0] wideArr;
    logic [1:0] lowArr;
    logic [1:0][MAIN_W-1:0] mainArr;
    logic [1:0][EX_W-1:0] fourthArr;

    assign pixelArr = {pixelBIn, pixelAIn};
    assign laneEnArr = {stateReg.outBEn, stateReg.outAEn};
    assign wideArr = {stateReg.bWide, stateReg.aWide};
    // Output B has no low-bit format control here, it always uses top bits
    assign lowArr = {1'h0, stateReg.aLow};

    genvar ch;
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
        bioc_lane_map #(
            .COLOUR_W(COLOUR_W)
        ) u_map (
            .clk_sys(clk_sys),
            .rst(rst),
            .pixel(pixelArr[ch]),
            .laneEnable(laneEnArr[ch]),
            .fourthEnable(wideArr[ch]),
            .lowBitsOnFourth(lowArr[ch]),
            .mainLanes(mainArr[ch]),
            .fourthLane(fourthArr[ch])
        );
    end

    assign prdata = stateReg.rdata;
    assign pready = stateReg.ready;
    assign pslverr = stateReg.err;
    assign activePixelFlag = stateReg.activeFlag;
    assign lineSync = stateReg.lineSync;
    assign frameSync = stateReg.frameSync;
    assign inADataEqLevel = stateReg.aDataLvl;
    assign inBDataEqLevel = stateReg.bDataLvl;
    assign inAClockEqLevel = stateReg.aClkLvl;
    assign inBClockEqLevel = stateReg.bClkLvl;
    assign inAClockBand = stateReg.bandAReg;
    assign inBClockBand = stateReg.bandBReg;
    assign inAClockBandValid = stateReg.aBandOk;
    assign inBClockBandValid = stateReg.bBandOk;
    assign channelMode = stateReg.chanMode;
    assign outAEnable = stateReg.outAEn;
    assign outBEnable = stateReg.outBEn;
    assign dualLink = stateReg.dual;
    assign twoSingleLinks = stateReg.twoSingle;
    assign outAFourthLaneEnable = stateReg.aWide;
    assign outBFourthLaneEnable = stateReg.bWide;
    assign outAColour18 = mainArr[0];
    assign outBColour18 = mainArr[1];
    assign outAFourthLane = fourthArr[0];
    assign outBFourthLane = fourthArr[1];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    chk_apb_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");

    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside the access cycle");

    chk_data_eq_one: assert property (
        ($past(stateReg.eqReg[7:6]) == 2'h1) |-> (inADataEqLevel == 2'h1))
        else $error("data equalization code 01 not 1 dB");

    chk_clock_eq_two: assert property (
        ($past(stateReg.eqReg[1:0]) == 2'h3) |-> (inBClockEqLevel == 2'h2))
        else $error("clock equalization code 11 not 2 dB");

    chk_band_rsvd: assert property (
        ($past(stateReg.bandBReg) == 8'h65) |-> !inBClockBandValid)
        else $error("reserved clock band flagged valid");

    chk_a_wide: assert property (
        stateReg.fmtReg[3] |=> outAFourthLaneEnable)
        else $error("output A fourth lane off in 24 bit mode");

    chk_b_wide: assert property (
        (stateReg.fmtReg[2] && !stateReg.fmtReg[4]) |=> outBFourthLaneEnable)
        else $error("output B fourth lane off in 24 bit mode");

    chk_mode_single: assert property (
        (!stateReg.fmtReg[4] && modeNow == 2'h1)
        |=> (dualLink && channelMode == 2'h1))
        else $error("single channel mode does not give dual link");

    chk_data_eq_rsvd: assert property (
        ($past(stateReg.eqReg[7:6]) == 2'h2) |-> (inADataEqLevel == 2'h0))
        else $error("reserved data equalization code not treated as none");

    chk_data_eq_two: assert property (
        ($past(stateReg.eqReg[5:4]) == 2'h3) |-> (inBDataEqLevel == 2'h2))
        else $error("data equalization code 11 not 2 dB");

    chk_clock_eq_one: assert property (
        ($past(stateReg.eqReg[3:2]) == 2'h1) |-> (inAClockEqLevel == 2'h1))
        else $error("clock equalization code 01 not 1 dB");

    chk_band_write: assert property (
        (writeStrobe && wordIdx == `BIOC_IDX_BAND_A)
        |=> (inAClockBand == $past(pwdata[7:0])) ##1
            (inAClockBandValid == ((inAClockBand >= 8'h08) && (inAClockBand <= 8'h64))))
        else $error("clock band write or range check wrong");

    chk_active_polarity: assert property (
        !$past(rst) |-> activePixelFlag == ($past(activeFlagIn) ^ $past(stateReg.fmtReg[7])))
        else $error("active pixel flag polarity wrong");

    chk_line_polarity: assert property (
        (!rst && lineSyncIn && stateReg.fmtReg[6]) |=> !lineSync)
        else $error("inverted line sync not driven low");

    chk_frame_polarity: assert property (
        (frameSyncIn && !stateReg.fmtReg[5]) |=> frameSync)
        else $error("normal frame sync not driven high");

    chk_two_single: assert property (
        (!stateReg.fmtReg[4] && modeNow == 2'h2)
        |=> (outAEnable && outBEnable && twoSingleLinks && !dualLink))
        else $error("two single links not set up");

    chk_single_link: assert property (
        stateReg.fmtReg[4] [*2] |=> (outAEnable && !outBEnable
            && outBColour18 == '0 && outBFourthLane == '0))
        else $error("single link leaves output B active");

    chk_a_narrow: assert property (
        (!stateReg.fmtReg[3]) [*2] |=> (outAFourthLane == '0 && !outAFourthLaneEnable))
        else $error("output A fourth lane active in 18 bit mode");

    chk_b_narrow: assert property (
        (!stateReg.fmtReg[2]) [*2] |=> (outBFourthLane == '0 && !outBFourthLaneEnable))
        else $error("output B fourth lane active in 18 bit mode");

    chk_a_low_bits: assert property (
        (stateReg.fmtReg[1] && stateReg.fmtReg[3]) [*2]
        |=> (outAFourthLane == {$past(pixelAIn[17:16]), $past(pixelAIn[9:8]),
            $past(pixelAIn[1:0])}))
        else $error("fourth lane does not carry low bits");

    chk_a_convert: assert property (
        (stateReg.fmtReg[1] && !stateReg.fmtReg[3]) [*2]
        |=> (outAColour18[17:12] == $past(pixelAIn[23:18]) && outAFourthLane == '0))
        else $error("24 to 18 bit conversion wrong");

    chk_mode_dual: assert property (
        (!stateReg.fmtReg[4] && modeNow == 2'h0)
        |=> (dualLink && channelMode == 2'h0))
        else $error("dual channel mode does not give dual link");

endmodule : bioc_regs

`default_nettype wire

// ### verif/bioc_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bioc_cfg.svh"

module bioc_regs_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic actIn = 1'b0;
    logic lineIn = 1'b0;
    logic frameIn = 1'b0;
    logic [23:0] pixA = 24'h0;
    logic [23:0] pixB = 24'h0;
    logic activePixelFlag, lineSync, frameSync;
    logic [1:0] eqAD, eqBD, eqAC, eqBC, chanMode;
    logic [7:0] bandA, bandB;
    logic bandAOk, bandBOk, aEn, bEn, dual, twoSingle, aFourEn, bFourEn;
    logic [17:0] a18, b18;
    logic [5:0] a6, b6;
    logic [33:0] gotSt;
    logic [7:0] m [0:63];
    logic [15:0] vSeed = 16'hc2a6;
    logic [15:0] wSeed = 16'hc2a6;
    logic [50:0] vPrev = 51'h0;
    logic vidChk = 1'b0;
    int n_mismatch = 0;
    int n_checks = 0;

    initial forever #4 clk_sys = ~clk_sys;

    bioc_regs dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .activeFlagIn(actIn), .lineSyncIn(lineIn),
        .frameSyncIn(frameIn), .pixelAIn(pixA), .pixelBIn(pixB),
        .activePixelFlag(activePixelFlag), .lineSync(lineSync), .frameSync(frameSync),
        .inADataEqLevel(eqAD), .inBDataEqLevel(eqBD), .inAClockEqLevel(eqAC),
        .inBClockEqLevel(eqBC), .inAClockBand(bandA), .inBClockBand(bandB),
        .inAClockBandValid(bandAOk), .inBClockBandValid(bandBOk), .channelMode(chanMode),
        .outAEnable(aEn), .outBEnable(bEn), .dualLink(dual), .twoSingleLinks(twoSingle),
        .outAFourthLaneEnable(aFourEn), .outBFourthLaneEnable(bFourEn),
        .outAColour18(a18), .outBColour18(b18), .outAFourthLane(a6), .outBFourthLane(b6));

    assign gotSt = {eqAD, eqBD, eqAC, eqBC, bandA, bandB, bandAOk, bandBOk, chanMode,
        aEn, bEn, dual, twoSingle, aFourEn, bFourEn};

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [7:0] wmask(input logic [5:0] i);
        case (i)
            `BIOC_IDX_MODE: return `BIOC_MASK_MODE;
            `BIOC_IDX_EQ: return `BIOC_MASK_EQ;
            `BIOC_IDX_BAND_A, `BIOC_IDX_BAND_B: return `BIOC_MASK_BAND;
            `BIOC_IDX_FMT: return `BIOC_MASK_FMT;
            default: return 8'h00;
        endcase
    endfunction : wmask

    function automatic logic [1:0] lvl(input logic [1:0] c);
        // Reserved code falls back to no equalization
        return (c == 2'h1) ? 2'h1 : ((c == 2'h3) ? 2'h2 : 2'h0);
    endfunction : lvl

    function automatic logic bok(input logic [7:0] b);
        return b >= 8'h08 && b <= 8'h64;
    endfunction : bok

    function automatic logic [33:0] exp_st();
        logic [7:0] e;
        logic [7:0] f;
        logic [1:0] md;
        logic two;
        e = m[`BIOC_IDX_EQ];
        f = m[`BIOC_IDX_FMT];
        md = m[`BIOC_IDX_MODE][6:5];
        two = !f[4];
        return {lvl(e[7:6]), lvl(e[5:4]), lvl(e[3:2]), lvl(e[1:0]), m[`BIOC_IDX_BAND_A],
            m[`BIOC_IDX_BAND_B], bok(m[`BIOC_IDX_BAND_A]), bok(m[`BIOC_IDX_BAND_B]), md,
            1'b1, two, two && md <= 2'h1, two && md == 2'h2, f[3], f[2] && two};
    endfunction : exp_st

    function automatic logic [23:0] lanes(input logic [23:0] p, input logic low);
        logic [17:0] mn;
        logic [5:0] fr;
        for (int c = 0; c < 3; c++) begin
            mn[6*c+:6] = low ? p[8*c+2+:6] : p[8*c+:6];
            fr[2*c+:2] = low ? p[8*c+:2] : p[8*c+6+:2];
        end
        return {mn, fr};
    endfunction : lanes

    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: port value %h, expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_rd(input logic [31:0] gd, input logic ge, input logic [31:0] ed,
                            input logic ee);
        n_checks++;
        if (gd !== ed || ge !== ee) begin
            n_mismatch++;
            $display("ERROR at %0t: read %h err %b, expected %h err %b", $time, gd, ge, ed, ee);
        end
    endtask : check_rd

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic er);
        int k;
        wSeed = lfsr(wSeed);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, wSeed[1:0]};
        pwdata <= {wSeed, wSeed[7:0], d};
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s);
        logic [31:0] rd;
        logic er;
        apb(idx, 1'b1, d, s, rd, er);
        check_val(64'(er), 64'(wmask(idx) == 8'h00));
        if (wmask(idx) != 8'h00 && s[0]) m[idx] = d & wmask(idx);
    endtask : wr

    task automatic rdchk(input logic [5:0] idx);
        logic [31:0] rd;
        logic er;
        apb(idx, 1'b0, 8'h00, 4'hf, rd, er);
        check_rd(rd, er, (wmask(idx) != 8'h00) ? {24'h0, m[idx]} : 32'h0, wmask(idx) == 8'h00);
    endtask : rdchk

    task automatic settle();
        repeat (4) @(posedge clk_sys);
        #1;
        check_val(64'(gotSt), 64'(exp_st()));
    endtask : settle

    task automatic vid(input int n);
        vidChk = 1'b1;
        repeat (n) @(posedge clk_sys);
        #1;
        vidChk = 1'b0;
    endtask : vid

    task automatic do_reset();
        vidChk = 1'b0;
        @(posedge clk_sys);
        rst <= 1'b1;
        m[`BIOC_IDX_MODE] = `BIOC_RST_MODE;
        m[`BIOC_IDX_EQ] = `BIOC_RST_EQ;
        m[`BIOC_IDX_BAND_A] = `BIOC_RST_BAND;
        m[`BIOC_IDX_BAND_B] = `BIOC_RST_BAND;
        m[`BIOC_IDX_FMT] = `BIOC_RST_FMT;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
    endtask : do_reset

    // Outputs seen at an edge reflect the inputs captured one edge earlier
    always @(posedge clk_sys) begin : vid_mon
        logic [7:0] f;
        logic [23:0] la;
        logic [23:0] lb;
        logic [63:0] r;
        logic [15:0] s;
        f = m[`BIOC_IDX_FMT];
        la = lanes(vPrev[47:24], f[1]) & {18'h3ffff, {6{f[3]}}};
        lb = lanes(vPrev[23:0], 1'b0) & {{18{!f[4]}}, {6{f[2] && !f[4]}}};
        if (vidChk) begin
            check_val(64'({activePixelFlag, lineSync, frameSync}), 64'(vPrev[50:48] ^ f[7:5]));
            check_val(64'({a18, a6}), 64'(la));
            check_val(64'({b18, b6}), 64'(lb));
        end
        vPrev <= {actIn, lineIn, frameIn, pixA, pixB};
        s = vSeed;
        for (int k = 0; k < 4; k++) begin
            s = lfsr(s);
            r[16*k+:16] = s;
        end
        vSeed <= s;
        pixA <= r[23:0];
        pixB <= r[47:24];
        {actIn, lineIn, frameIn} <= r[63:61];
    end

    initial begin : main
        logic [5:0] idxTab [0:5];
        logic [7:0] bandTab [0:5];
        logic [7:0] fmtTab [0:7];
        idxTab = '{`BIOC_IDX_MODE, `BIOC_IDX_EQ, `BIOC_IDX_BAND_A, `BIOC_IDX_BAND_B,
            `BIOC_IDX_FMT, 6'h19};
        bandTab = '{8'h07, 8'h08, 8'h64, 8'h65, 8'h00, 8'hff};
        // Low-bit format is chosen with output A at 24 bit (0Ah, 1Eh, FFh) and at 18 bit (02h)
        fmtTab = '{8'h70, 8'h00, 8'he8, 8'h0a, 8'h02, 8'h0c, 8'h1e, 8'hff};
        do_reset();
        for (int i = 0; i < 6; i++) rdchk(idxTab[i]);
        settle();
        vid(20);
        rdchk(6'h14);
        wr(6'h3f, 8'hff, 4'hf);
        rdchk(6'h3f);
        wr(`BIOC_IDX_EQ, 8'hff, 4'he);
        rdchk(`BIOC_IDX_EQ);
        for (int i = 0; i < 4; i++) begin
            wr(`BIOC_IDX_EQ, {2'(i), 2'(i + 1), 2'(i + 2), 2'(i + 3)}, 4'h1);
            settle();
            rdchk(`BIOC_IDX_EQ);
        end
        for (int j = 0; j < 6; j++) begin
            wr(`BIOC_IDX_BAND_A, bandTab[j], 4'hf);
            wr(`BIOC_IDX_BAND_B, bandTab[5 - j], 4'h1);
            settle();
            rdchk(`BIOC_IDX_BAND_A);
            rdchk(`BIOC_IDX_BAND_B);
        end
        for (int md = 0; md < 4; md++) begin
            for (int j = 0; j < 8; j++) begin
                wr(`BIOC_IDX_MODE, {wSeed[7], 2'(md), wSeed[4:0]}, 4'hf);
                wr(`BIOC_IDX_FMT, fmtTab[j] | {7'h0, wSeed[3]}, 4'hf);
                settle();
                rdchk(`BIOC_IDX_MODE);
                rdchk(`BIOC_IDX_FMT);
                vid(16);
            end
        end
        for (int i = 0; i < 24; i++) begin
            wr(idxTab[wSeed[2:0] % 6], wSeed[15:8], wSeed[7:4]);
            rdchk(idxTab[i % 6]);
        end
        settle();
        vid(12);
        // Second reset in mid-run must bring every register back
        do_reset();
        for (int i = 0; i < 6; i++) rdchk(idxTab[i]);
        settle();
        vid(12);
        end_sim();
    end

    initial begin : watchdog
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        end_sim();
    end
endmodule : bioc_regs_tb_top
`default_nettype wire
